// *** common/pfr_pkg.sv ***
/*
  Constants, reset values, field positions and lookup helpers for the fan start and ramp block.
  Assumes a 100 MHz clock and a 32-bit Avalon-MM slave with word-indexed registers.
*/
`default_nettype none
package pfr_pkg;
  // register indexes, byte address is four times the index
  localparam logic [7:0] IDX_CFG6 = 8'h10;
  localparam logic [7:0] IDX_CUR_DUTY = 8'h32;
  localparam logic [7:0] IDX_TEMP = 8'h33;
  localparam logic [7:0] IDX_PECI_CFG = 8'h36;
  localparam logic [7:0] IDX_START = 8'h3B;
  localparam logic [7:0] IDX_RANGE = 8'h3C;
  localparam logic [7:0] IDX_CFG1 = 8'h40;
  localparam logic [7:0] IDX_MIN_DUTY = 8'h64;
  localparam logic [7:0] IDX_CFG5 = 8'h7C;
  // reset values
  localparam logic [7:0] START_RST = 8'hE0;
  localparam logic [7:0] RANGE_RST = 8'hC0;
  localparam logic [7:0] CFG1_RST = 8'h04;
  localparam logic [7:0] PECI_CFG_RST = 8'h00;
  localparam logic [7:0] CFG5_RST = 8'h00;
  localparam logic [7:0] CFG6_RST = 8'h00;
  localparam logic [7:0] MIN_DUTY_RST = 8'h80;
  // field positions
  localparam int LOCK_BIT = 1;
  localparam int ENC_BIT = 0;
  localparam int ALT_BIT = 7;
  localparam int RAMP_MSB = 2;
  localparam int AVG_MSB = 2;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int PECI_READ_TIME_NS = 1000;
  localparam int READ_CYCLES = (PECI_READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // duty gained per degree above the start temperature
  localparam logic [4:0] SLOPE_PER_DEG = 5'h08;
  // slower table ratio, 37.5 s against 52.2 s
  localparam logic [9:0] ALT_NUM = 10'h177;
  localparam logic [9:0] ALT_DEN = 10'h20A;
  localparam logic [7:0] PWM_LAST = 8'hFE;

  typedef enum logic [0:0] {
    PFR_BUS_IDLE = 1'b0,
    PFR_BUS_ACK = 1'b1
  } pfr_bus_state_type;

  // duty step per refresh for each ramp code
  function automatic logic [7:0] pfr_step(input logic [2:0] code);
    case (code)
      3'h0: pfr_step = 8'h01;
      3'h1: pfr_step = 8'h02;
      3'h2: pfr_step = 8'h03;
      3'h3: pfr_step = 8'h04;
      3'h4: pfr_step = 8'h08;
      3'h5: pfr_step = 8'h0C;
      3'h6: pfr_step = 8'h18;
      default: pfr_step = 8'h30;
    endcase
  endfunction

  // number of peci readings per refresh; reserved code treated as longest
  function automatic logic [16:0] pfr_reads(input logic [2:0] code);
    case (code)
      3'h0: pfr_reads = 17'h00010;
      3'h1: pfr_reads = 17'h00800;
      3'h2: pfr_reads = 17'h01000;
      3'h3: pfr_reads = 17'h02000;
      3'h4: pfr_reads = 17'h04000;
      3'h5: pfr_reads = 17'h08000;
      default: pfr_reads = 17'h10000;
    endcase
  endfunction
endpackage
`default_nettype wire

// *** rtl/pfr_fan_ramp.sv ***
/*
  Peci-driven fan start and duty ramp with its Avalon-MM register slave.
  Assumes a synchronous peci temperature input and a master that holds requests until waitrequest is low.
*/
// Notes on behaviour
// - above start temperature, run minimum then slope
// - start temperature resets to 0xE0
// - lock makes start temperature read-only
// - ramp code limits duty change rate
// - codes map to steps 1..48
// - normal table gives 37.5 to 0.8 s
// - ramp paced by peci refresh rate
// - ramp register resets 0xC0, locked writes fail
// - encoding bit selects twos or offset-64
// - refresh interval equals smoothing interval
`default_nettype none
module pfr_fan_ramp import pfr_pkg::*; #(
  parameter int READ_CYCLES_P = READ_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] peci_temperature,
  output logic [7:0] fan_duty,
  output logic fan_pwm_output
);
  // bus state
  pfr_bus_state_type bus_q, bus_d;
  logic [31:0] rdata_q, rdata_d;
  logic wait_q, wait_d;
  // registers
  logic [7:0] start_q, start_d;
  logic [7:0] range_q, range_d;
  logic [7:0] cfg1_q, cfg1_d;
  logic [7:0] peci_cfg_q, peci_cfg_d;
  logic [7:0] cfg5_q, cfg5_d;
  logic [7:0] cfg6_q, cfg6_d;
  logic [7:0] min_duty_q, min_duty_d;
  // control path
  logic [31:0] cnt_q, cnt_d;
  logic refresh_q, refresh_d;
  logic [9:0] acc_q, acc_d;
  logic [7:0] target_q, target_d;
  logic [7:0] duty_q, duty_d;
  logic [7:0] pwm_cnt_q, pwm_cnt_d;
  logic pwm_q, pwm_d;

  logic [7:0] idx;
  logic wr_fire;
  logic lock;
  logic step_en;
  logic [7:0] step;
  logic [31:0] interval;
  logic signed [9:0] temp_s, start_s, diff;
  logic above;
  logic [13:0] raw_target;
  logic [10:0] acc_sum;

  assign idx = avs_address[9:2];
  assign wr_fire = (bus_q == PFR_BUS_ACK) && avs_write && avs_byteenable[0];
  assign lock = cfg1_q[LOCK_BIT];

  // bus handshake: one wait cycle, then a single answer cycle
  always_comb begin
    bus_d = bus_q;
    wait_d = 1'b1;
    rdata_d = rdata_q;
    case (bus_q)
      PFR_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          bus_d = PFR_BUS_ACK;
          wait_d = 1'b0;
          case (idx)
            IDX_CFG6: rdata_d = {24'h0, cfg6_q};
            IDX_CUR_DUTY: rdata_d = {24'h0, duty_q};
            IDX_TEMP: rdata_d = {24'h0, peci_temperature};
            IDX_PECI_CFG: rdata_d = {24'h0, peci_cfg_q};
            IDX_START: rdata_d = {24'h0, start_q};
            IDX_RANGE: rdata_d = {24'h0, range_q};
            IDX_CFG1: rdata_d = {24'h0, cfg1_q};
            IDX_MIN_DUTY: rdata_d = {24'h0, min_duty_q};
            IDX_CFG5: rdata_d = {24'h0, cfg5_q};
            default: rdata_d = 32'h0000_0000;
          endcase
        end
      end
      PFR_BUS_ACK: bus_d = PFR_BUS_IDLE;
      default: bus_d = PFR_BUS_IDLE;
    endcase
  end

  // register writes, locked ones dropped
  always_comb begin
    start_d = start_q;
    range_d = range_q;
    cfg1_d = cfg1_q;
    peci_cfg_d = peci_cfg_q;
    cfg5_d = cfg5_q;
    cfg6_d = cfg6_q;
    min_duty_d = min_duty_q;
    if (wr_fire) begin
      case (idx)
        IDX_START: if (!lock) start_d = avs_writedata[7:0];
        IDX_RANGE: if (!lock) range_d = avs_writedata[7:0];
        IDX_PECI_CFG: if (!lock) peci_cfg_d = avs_writedata[7:0];
        IDX_CFG1: cfg1_d = avs_writedata[7:0] | {6'h00, lock, 1'b0}; // only the lock is sticky
        IDX_CFG5: cfg5_d = avs_writedata[7:0];
        IDX_CFG6: cfg6_d = avs_writedata[7:0];
        IDX_MIN_DUTY: if (!lock) min_duty_d = avs_writedata[7:0];
        default: start_d = start_q;
      endcase
    end
  end

  // temperatures as signed degrees
  always_comb begin
    if (cfg5_q[ENC_BIT]) begin
      temp_s = $signed({2'b00, peci_temperature}) - 10'sd64;
      start_s = $signed({2'b00, start_q}) - 10'sd64;
    end else begin
      temp_s = $signed({{2{peci_temperature[7]}}, peci_temperature});
      start_s = $signed({{2{start_q[7]}}, start_q});
    end
    diff = temp_s - start_s;
    above = (diff > 10'sd0);
    raw_target = {6'h00, min_duty_q} + (14'(diff[8:0]) * 14'(SLOPE_PER_DEG)); // full-width product
  end

  // refresh pacing and ramp stepping
  always_comb begin
    interval = 32'(pfr_reads(peci_cfg_q[AVG_MSB:0]) * READ_CYCLES_P);
    refresh_d = 1'b0;
    cnt_d = cnt_q + 32'h1;
    if (cnt_q >= interval - 32'h1) begin
      cnt_d = 32'h0;
      refresh_d = 1'b1;
    end
    acc_sum = {1'b0, acc_q} + {1'b0, ALT_NUM};
    acc_d = acc_q;
    step_en = 1'b0;
    if (refresh_q) begin
      if (cfg6_q[ALT_BIT]) begin
        if (acc_sum >= {1'b0, ALT_DEN}) begin
          acc_d = 10'(acc_sum - {1'b0, ALT_DEN});
          step_en = 1'b1;
        end else begin
          acc_d = acc_sum[9:0];
        end
      end else begin
        step_en = 1'b1;
      end
    end
    // target: off below start, minimum then slope above
    if (!above) begin
      target_d = 8'h00;
    end else if (raw_target > 14'h00FF) begin
      target_d = 8'hFF;
    end else begin
      target_d = raw_target[7:0];
    end
    step = pfr_step(range_q[RAMP_MSB:0]);
    duty_d = duty_q;
    if (step_en) begin
      if (duty_q < target_q) begin
        duty_d = ((target_q - duty_q) <= step) ? target_q : duty_q + step;
      end else if (duty_q > target_q) begin
        duty_d = ((duty_q - target_q) <= step) ? target_q : duty_q - step;
      end
    end
    // pwm wave with period of 255 clocks
    pwm_cnt_d = (pwm_cnt_q == PWM_LAST) ? 8'h00 : pwm_cnt_q + 8'h01;
    pwm_d = (pwm_cnt_q < duty_q);
  end

  // state registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_q <= PFR_BUS_IDLE;
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
      start_q <= START_RST;
      range_q <= RANGE_RST;
      cfg1_q <= CFG1_RST;
      peci_cfg_q <= PECI_CFG_RST;
      cfg5_q <= CFG5_RST;
      cfg6_q <= CFG6_RST;
      min_duty_q <= MIN_DUTY_RST;
      cnt_q <= 32'h0;
      refresh_q <= 1'b0;
      acc_q <= 10'h000;
      target_q <= 8'h00;
      duty_q <= 8'h00;
      pwm_cnt_q <= 8'h00;
      pwm_q <= 1'b0;
    end else begin
      bus_q <= bus_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      start_q <= start_d;
      range_q <= range_d;
      cfg1_q <= cfg1_d;
      peci_cfg_q <= peci_cfg_d;
      cfg5_q <= cfg5_d;
      cfg6_q <= cfg6_d;
      min_duty_q <= min_duty_d;
      cnt_q <= cnt_d;
      refresh_q <= refresh_d;
      acc_q <= acc_d;
      target_q <= target_d;
      duty_q <= duty_d;
      pwm_cnt_q <= pwm_cnt_d;
      pwm_q <= pwm_d;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign fan_duty = duty_q;
  assign fan_pwm_output = pwm_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_START_RESET: assert property ($fell(rst) |-> start_q == START_RST && range_q == RANGE_RST)
    else $error("start or ramp register not at reset value");
  AST_LOCK_START: assert property (lock && wr_fire && idx == IDX_START |=> $stable(start_q))
    else $error("locked start temperature changed");
  AST_LOCK_RANGE: assert property (lock && wr_fire && idx == IDX_RANGE |=> $stable(range_q))
    else $error("locked ramp register changed");
  AST_STEP_LIMIT: assert property ($changed(duty_q) |-> ((duty_q > $past(duty_q)) ?
      (duty_q - $past(duty_q)) : ($past(duty_q) - duty_q)) <= pfr_step($past(range_q[RAMP_MSB:0])))
    else $error("duty moved more than one step");
  AST_NO_OVERSHOOT: assert property (step_en && duty_q < target_q |=> duty_q <= $past(target_q))
    else $error("duty overshot target");
  AST_HOLD: assert property (!step_en |=> $stable(duty_q))
    else $error("duty moved without a refresh");
  AST_BELOW_START: assert property (!above ##1 !above |-> target_q == 8'h00)
    else $error("target nonzero below start");
  AST_ABOVE_MIN: assert property (above ##1 above && $stable(min_duty_q) |-> target_q >= min_duty_q)
    else $error("target under minimum above start");
  AST_REFRESH_GAP: assert property (refresh_q |=> !refresh_q ##1 !refresh_q)
    else $error("refresh ticks too close");
  AST_ALT_SKIP: assert property (refresh_q && cfg6_q[ALT_BIT] && acc_sum < {1'b0, ALT_DEN} |-> !step_en)
    else $error("slow table stepped early");
  AST_BUS_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer longer than one cycle");

  COV_RAMP_UP: cover property (step_en && duty_q < target_q ##1 duty_q == target_q);
  COV_LOCKED_WRITE: cover property (lock && wr_fire && idx == IDX_START);
  COV_ALT_STEP: cover property (cfg6_q[ALT_BIT] && step_en);
  COV_OFFSET_ABOVE: cover property (cfg5_q[ENC_BIT] && above);
endmodule // pfr_fan_ramp
`default_nettype wire

// *** verification/pfr_fan_model.sv ***
/*
  Fan and temperature source model: drives the peci reading and counts pwm high cycles per 255-cycle window.
  Assumes the pwm counter period of the design is 255 clocks.
*/
`default_nettype none
module pfr_fan_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] temp_set,
  input wire logic fan_pwm_output,
  output logic [7:0] peci_temperature,
  output logic [8:0] high_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] win_q;
  logic [8:0] acc_q;
  // reading follows the set value, pwm highs latched each window
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      peci_temperature <= 8'h00;
      win_q <= 8'h00;
      acc_q <= 9'h000;
      high_count <= 9'h000;
    end else begin
      peci_temperature <= temp_set;
      win_q <= (win_q == 8'hFE) ? 8'h00 : win_q + 8'h01;
      acc_q <= (win_q == 8'hFE) ? 9'h000 : acc_q + {8'h00, fan_pwm_output};
      if (win_q == 8'hFE) high_count <= acc_q + {8'h00, fan_pwm_output};
    end
  end
endmodule // pfr_fan_model
`default_nettype wire

// *** verification/testbench.sv ***
/*
  Self-checking bench for the fan start and ramp block over Avalon-MM.
  Assumes READ_CYCLES_P of 1, so a code 0 refresh is 16 clocks.
*/
`default_nettype none
module testbench;
  import pfr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, fan_pwm_output;
  logic [9:0] avs_address = 10'h000;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0] avs_byteenable = 4'hF;
  logic [7:0] peci_temperature, fan_duty, temp_set = 8'h00, rd;
  logic [8:0] high_count;
  logic [7:0] steps [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0C, 8'h18, 8'h30};
  int mismatches = 0, checks_done = 0, n;
  pfr_fan_ramp #(.READ_CYCLES_P(1)) i_dut (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .peci_temperature(peci_temperature),
    .fan_duty(fan_duty), .fan_pwm_output(fan_pwm_output));
  pfr_fan_model i_fan (.clk(clk), .rst(rst), .temp_set(temp_set), .fan_pwm_output(fan_pwm_output),
    .peci_temperature(peci_temperature), .high_count(high_count));
  // clock and watchdog
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one bus cycle: request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd_check(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    check({24'h0, rd}, {24'h0, exp});
  endtask
  // temperature source changes on the rising edge
  task automatic set_temp(input logic [7:0] v);
    @(posedge clk);
    temp_set <= v;
  endtask
  // clock cycles until duty next changes, left in n
  task automatic wait_change(input int lim);
    logic [7:0] old;
    old = fan_duty;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (fan_duty === old && n < lim);
  endtask
  // drop below start with the fastest code and wait for zero duty
  task automatic go_zero();
    bus(1'b1, IDX_RANGE, 8'hC7);
    set_temp(8'h00);
    repeat (4) @(negedge clk);
    n = 0;
    while (fan_duty !== 8'h00 && n < 400) begin
      @(negedge clk);
      n++;
    end
    check(fan_duty, 8'h00);
  endtask
  task automatic t_reset();
    @(negedge clk);
    check(fan_duty, 8'h00);
    rd_check(IDX_START, 8'hE0);
    rd_check(IDX_RANGE, 8'hC0);
    rd_check(8'h01, 8'h00);
  endtask
  task automatic t_start_enc();
    bus(1'b1, IDX_START, 8'h10);
    go_zero();
    bus(1'b1, IDX_RANGE, 8'hC0);
    set_temp(8'h11);
    wait_change(100);
    check(fan_duty, 8'h01);
    wait_change(100);
    check(n, 16);
    bus(1'b1, IDX_RANGE, 8'hC7);
    repeat (200) @(negedge clk);
    check(fan_duty, 8'h88);
    // 0x90 is below start as twos complement, far above as offset-64
    set_temp(8'h90);
    repeat (200) @(negedge clk);
    check(fan_duty, 8'h00);
    bus(1'b1, IDX_CFG5, 8'h01);
    repeat (200) @(negedge clk);
    check(fan_duty, 8'hFF);
    bus(1'b1, IDX_CFG5, 8'h00);
  endtask
  task automatic t_codes();
    for (int c = 7; c >= 0; c--) begin
      go_zero();
      bus(1'b1, IDX_RANGE, 8'hC0 | c[7:0]);
      set_temp(8'h14);
      wait_change(100);
      check(fan_duty, steps[c]);
    end
    go_zero();
    set_temp(8'h14);
    repeat (200) @(negedge clk);
    check(fan_duty, 8'hA0);
    repeat (520) @(negedge clk);
    check(high_count, 9'h0A0);
  endtask
  task automatic t_rate();
    int s;
    go_zero();
    bus(1'b1, IDX_RANGE, 8'hC0);
    bus(1'b1, IDX_PECI_CFG, 8'h01);
    set_temp(8'h15);
    wait_change(5000);
    wait_change(5000);
    check(n, 2048);
    bus(1'b1, IDX_PECI_CFG, 8'h00);
    go_zero();
    bus(1'b1, IDX_RANGE, 8'hC0);
    bus(1'b1, IDX_CFG6, 8'h80);
    set_temp(8'h30);
    wait_change(200);
    s = 0;
    for (int i = 0; i < 4; i++) begin
      wait_change(200);
      check(n == 16 || n == 32, 1'b1);
      s += n;
    end
    check(s > 64 && s <= 128, 1'b1);
    bus(1'b1, IDX_CFG6, 8'h00);
  endtask
  task automatic t_lock();
    bus(1'b1, IDX_CFG1, 8'h02);
    bus(1'b1, IDX_START, 8'h55);
    bus(1'b1, IDX_RANGE, 8'h07);
    rd_check(IDX_START, 8'h10);
    rd_check(IDX_RANGE, 8'hC0);
    bus(1'b1, IDX_CFG1, 8'h00);
    rd_check(IDX_CFG1, 8'h02);
    // mid-run reset brings back defaults and clears the lock
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_check(IDX_START, 8'hE0);
    rd_check(IDX_CFG1, 8'h04);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_start_enc();
    t_codes();
    t_rate();
    t_lock();
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
